/* verilog/epi_top.sv */
// epi_top: quadrature counter, limit-frequency and amplitude monitor, serial absolute reader
// assumes QDEC_CLK_I runs freely and much faster than the track edges;
// the track, reference, amplitude and serial data inputs are asynchronous and are synchronised here
`timescale 1ns/1ps
module epi_top #(
	parameter int GATE_CYCLES = epi_pkg::GATE_CYC
) (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic QDEC_CLK_I,
	input wire logic TRACK_A_I,
	input wire logic TRACK_B_I,
	input wire logic REF_MARK_I,
	input wire logic AMP_OK_I,
	input wire logic [8:0] LIMIT_KHZ_I,
	input wire logic LIMIT_LOAD_I,
	input wire logic FAULT_CLR_I,
	input wire logic SSI_EN_I,
	input wire logic SSI_FAST_I,
	input wire logic [4:0] SSI_LEN_I,
	input wire logic SSI_GRAY_I,
	input wire logic SSI_ALARM_EN_I,
	input wire logic SSI_PAR_EN_I,
	input wire logic SSI_PAR_ODD_I,
	input wire logic SSI_DATA_I,
	output logic [8:0] LIMIT_KHZ_O,
	output logic [31:0] QPOS_O,
	output logic QDIR_O,
	output logic [31:0] REF_POS_O,
	output logic REF_SEEN_O,
	output logic QUAD_ERR_O,
	output logic FREQ_FAULT_O,
	output logic AMP_FAULT_O,
	output logic SSI_CLK_O,
	output logic [24:0] SSI_POS_O,
	output logic SSI_VALID_O,
	output logic SSI_ALARM_O,
	output logic SSI_PAR_ERR_O,
	output logic SSI_BUSY_O
);
	localparam int GW = $clog2(GATE_CYCLES + 1);
	localparam int PW = epi_pkg::POS_W;
	localparam int FW = epi_pkg::FRAME_W;

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// ---------------- link domain: quadrature decode ----------------
	logic link_rst_n;
	logic [1:0] ab_s;
	logic [1:0] ab_prev_ff;
	logic [PW-1:0] qcnt_ff;
	logic [PW-1:0] qgray_ff;
	logic arise_tgl_ff;
	logic err_tgl_ff;
	logic dir_ff;

	// release of the link reset is retimed to the link clock
	epi_sync #(.W(1)) u_link_rst (
		.clk_i(QDEC_CLK_I),
		.rst_n_i(RESETN_I),
		.d_i(1'b1),
		.q_o(link_rst_n)
	);

	epi_sync #(.W(2)) u_link_sync (
		.clk_i(QDEC_CLK_I),
		.rst_n_i(link_rst_n),
		.d_i({TRACK_A_I, TRACK_B_I}),
		.q_o(ab_s)
	);

	wire [1:0] ab_chg = ab_s ^ ab_prev_ff;
	wire step = ab_chg == 2'b01 || ab_chg == 2'b10;
	wire bad_step = &ab_chg;
	// A-previous equal to B-now means A leads
	wire step_up = ~(ab_prev_ff[1] ^ ab_s[0]);
	wire a_rise = ab_s[1] & ~ab_prev_ff[1];
	wire [PW-1:0] nxt_qcnt = step ? (step_up ? qcnt_ff + 1'b1 : qcnt_ff - 1'b1) : qcnt_ff;

	always_ff @(posedge QDEC_CLK_I or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ab_prev_ff <= '0;
			qcnt_ff <= '0;
			qgray_ff <= '0;
			arise_tgl_ff <= 1'b0;
			err_tgl_ff <= 1'b0;
			dir_ff <= 1'b0;
		end else begin
			ab_prev_ff <= ab_s;
			qcnt_ff <= nxt_qcnt;
			// one bit changes per step, so the sys side may sample it at any time
			qgray_ff <= nxt_qcnt ^ (nxt_qcnt >> 1);
			arise_tgl_ff <= arise_tgl_ff ^ a_rise;
			err_tgl_ff <= err_tgl_ff ^ bad_step;
			if (step) begin
				dir_ff <= step_up;
			end
		end
	end

	step_count_a: assert property (@(posedge QDEC_CLK_I) disable iff (!link_rst_n)
		step |=> qcnt_ff == ($past(step_up) ? $past(qcnt_ff) + 1'b1 : $past(qcnt_ff) - 1'b1))
		else $error("quadrature count did not follow the step");
	bad_step_a: assert property (@(posedge QDEC_CLK_I) disable iff (!link_rst_n)
		bad_step |=> err_tgl_ff != $past(err_tgl_ff) && qcnt_ff == $past(qcnt_ff))
		else $error("double track change not reported");
	bad_step_c: cover property (@(posedge QDEC_CLK_I) disable iff (!link_rst_n) bad_step);

	// ---------------- system domain: crossings ----------------
	logic [PW-1:0] qgray_s;
	logic arise_tgl_s;
	logic err_tgl_s;
	logic dir_s;
	logic ref_s;
	logic amp_ok_s;
	logic data_s;
	logic sys_rdy_s;

	// constant bit marks when the other bits hold real samples, not reset zeros
	epi_sync #(.W(PW + 7)) u_sys_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESETN_I),
		.d_i({1'b1, qgray_ff, arise_tgl_ff, err_tgl_ff, dir_ff, REF_MARK_I, AMP_OK_I, SSI_DATA_I}),
		.q_o({sys_rdy_s, qgray_s, arise_tgl_s, err_tgl_s, dir_s, ref_s, amp_ok_s, data_s})
	);

	logic arise_tgl_d_ff;
	logic err_tgl_d_ff;
	logic ref_d_ff;
	logic [8:0] lim_ff;
	logic [GW-1:0] gate_ff;
	logic [9:0] edges_ff;

	wire arise_ev = arise_tgl_s ^ arise_tgl_d_ff;
	wire err_ev = err_tgl_s ^ err_tgl_d_ff;
	wire ref_ev = ref_s & ~ref_d_ff;
	wire [PW-1:0] qpos_bin = gray2bin(qgray_s);
	wire gate_end = gate_ff == GW'(GATE_CYCLES - 1);
	wire [9:0] edges_inc = (&edges_ff) ? edges_ff : edges_ff + 1'b1;
	wire [9:0] nxt_edges = gate_end ? 10'h000 : (arise_ev ? edges_inc : edges_ff);
	// rising edges of A per millisecond read directly as kHz
	wire over_lim = edges_ff > {1'b0, lim_ff};
	wire [8:0] lim_clamped = (LIMIT_KHZ_I < epi_pkg::LIM_MIN_KHZ) ? epi_pkg::LIM_MIN_KHZ :
		(LIMIT_KHZ_I > epi_pkg::LIM_MAX_KHZ) ? epi_pkg::LIM_MAX_KHZ : LIMIT_KHZ_I;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			arise_tgl_d_ff <= 1'b0;
			err_tgl_d_ff <= 1'b0;
			ref_d_ff <= 1'b0;
			lim_ff <= epi_pkg::LIM_RST_KHZ;
			gate_ff <= '0;
			edges_ff <= '0;
		end else begin
			arise_tgl_d_ff <= arise_tgl_s;
			err_tgl_d_ff <= err_tgl_s;
			ref_d_ff <= ref_s;
			if (LIMIT_LOAD_I) begin
				lim_ff <= lim_clamped;
			end
			gate_ff <= gate_end ? '0 : gate_ff + 1'b1;
			edges_ff <= nxt_edges;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			QPOS_O <= '0;
			QDIR_O <= 1'b0;
			REF_POS_O <= '0;
			REF_SEEN_O <= 1'b0;
		end else begin
			QPOS_O <= qpos_bin;
			QDIR_O <= dir_s;
			if (ref_ev) begin
				REF_POS_O <= qpos_bin;
				REF_SEEN_O <= 1'b1;
			end
		end
	end

	// sticky faults: a new event wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			QUAD_ERR_O <= 1'b0;
			FREQ_FAULT_O <= 1'b0;
			AMP_FAULT_O <= 1'b0;
		end else begin
			QUAD_ERR_O <= err_ev | (QUAD_ERR_O & ~FAULT_CLR_I);
			FREQ_FAULT_O <= over_lim | (FREQ_FAULT_O & ~FAULT_CLR_I);
			AMP_FAULT_O <= (sys_rdy_s & ~amp_ok_s) | (AMP_FAULT_O & ~FAULT_CLR_I);
		end
	end

	assign LIMIT_KHZ_O = lim_ff;

	lim_range_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		lim_ff >= epi_pkg::LIM_MIN_KHZ && lim_ff <= epi_pkg::LIM_MAX_KHZ)
		else $error("limit frequency setting out of range");
	freq_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		over_lim |=> FREQ_FAULT_O)
		else $error("overspeed not flagged");
	amp_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		sys_rdy_s && !amp_ok_s |=> AMP_FAULT_O)
		else $error("amplitude fault not flagged");
	freq_fault_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) $rose(FREQ_FAULT_O));
	ref_seen_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) ref_ev && QDIR_O);

	// ---------------- system domain: serial absolute reader ----------------
	epi_pkg::epi_ssi_state_type st_ff;
	epi_pkg::epi_ssi_state_type nxt_st;
	logic [7:0] tick_ff;
	logic [4:0] bit_ff;
	logic [4:0] len_ff;
	logic fast_ff;
	logic gray_ff;
	logic alarm_en_ff;
	logic par_en_ff;
	logic par_odd_ff;
	logic prev_bit_ff;
	logic [FW-1:0] dec_ff;
	logic fin_ff;

	wire [7:0] half_lim = fast_ff ? 8'(epi_pkg::SSI_HALF_FAST - 1) :
		8'(epi_pkg::SSI_HALF_SLOW - 1);
	wire [7:0] mono_lim = fast_ff ? 8'(epi_pkg::TM_FAST_CYC - 1) :
		8'(epi_pkg::TM_SLOW_CYC - 1);
	wire [7:0] tick_lim = (st_ff == epi_pkg::SSI_MONO) ? mono_lim : half_lim;
	wire tick_end = tick_ff == tick_lim;
	wire [4:0] len_clamped = (SSI_LEN_I < epi_pkg::LEN_MIN) ? epi_pkg::LEN_MIN :
		(SSI_LEN_I > epi_pkg::LEN_MAX) ? epi_pkg::LEN_MAX : SSI_LEN_I;
	wire start = st_ff == epi_pkg::SSI_IDLE && SSI_EN_I;
	// bit is taken at the end of the high half, long after the encoder drove it
	wire sample = st_ff == epi_pkg::SSI_HIGH && tick_end;
	wire last_bit = bit_ff == len_ff - 5'h01;
	// Gray bits arrive MSB first, so a running xor yields binary
	wire dec_bit = gray_ff ? (prev_bit_ff ^ data_s) : data_s;
	wire [1:0] strip = {1'b0, alarm_en_ff} + {1'b0, par_en_ff};
	wire alarm_bit = alarm_en_ff & dec_ff[0];
	// parity covers every decoded bit except the alarm flag
	wire par_bad = par_en_ff & ((^dec_ff) ^ alarm_bit ^ par_odd_ff);
	wire [FW-1:0] pos_val = dec_ff >> strip;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			epi_pkg::SSI_IDLE: begin
				if (SSI_EN_I) begin
					nxt_st = epi_pkg::SSI_LOW;
				end
			end
			epi_pkg::SSI_LOW: begin
				if (tick_end) begin
					nxt_st = epi_pkg::SSI_HIGH;
				end
			end
			epi_pkg::SSI_HIGH: begin
				if (tick_end) begin
					nxt_st = last_bit ? epi_pkg::SSI_MONO : epi_pkg::SSI_LOW;
				end
			end
			default: begin
				if (tick_end) begin
					nxt_st = epi_pkg::SSI_IDLE;
				end
			end
		endcase
	end

	// reset lands in the recovery gap so the first frame also honours it
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_ff <= epi_pkg::SSI_MONO;
			tick_ff <= '0;
			bit_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			tick_ff <= (tick_end || nxt_st != st_ff) ? 8'h00 : tick_ff + 8'h01;
			if (start) begin
				bit_ff <= '0;
			end else if (sample) begin
				bit_ff <= bit_ff + 5'h01;
			end
		end
	end

	// config is frozen per frame; a change mid-frame cannot split a word
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			len_ff <= epi_pkg::LEN_MIN;
			fast_ff <= 1'b0;
			gray_ff <= 1'b0;
			alarm_en_ff <= 1'b0;
			par_en_ff <= 1'b0;
			par_odd_ff <= 1'b0;
		end else if (start) begin
			len_ff <= len_clamped;
			fast_ff <= SSI_FAST_I;
			gray_ff <= SSI_GRAY_I;
			alarm_en_ff <= SSI_ALARM_EN_I;
			par_en_ff <= SSI_PAR_EN_I;
			par_odd_ff <= SSI_PAR_ODD_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dec_ff <= '0;
			prev_bit_ff <= 1'b0;
			fin_ff <= 1'b0;
		end else begin
			fin_ff <= sample & last_bit;
			if (start) begin
				dec_ff <= '0;
				prev_bit_ff <= 1'b0;
			end else if (sample) begin
				dec_ff <= {dec_ff[FW-2:0], dec_bit};
				prev_bit_ff <= dec_bit;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			SSI_CLK_O <= 1'b1;
			SSI_POS_O <= '0;
			SSI_VALID_O <= 1'b0;
			SSI_ALARM_O <= 1'b0;
			SSI_PAR_ERR_O <= 1'b0;
		end else begin
			SSI_CLK_O <= nxt_st != epi_pkg::SSI_LOW;
			SSI_VALID_O <= fin_ff;
			if (fin_ff) begin
				SSI_POS_O <= pos_val;
				SSI_ALARM_O <= alarm_bit;
				SSI_PAR_ERR_O <= par_bad;
			end
		end
	end

	assign SSI_BUSY_O = st_ff == epi_pkg::SSI_LOW || st_ff == epi_pkg::SSI_HIGH;

	fast_rate_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		$fell(SSI_CLK_O) && fast_ff |-> ##19 !SSI_CLK_O ##1 SSI_CLK_O)
		else $error("fast serial clock low half wrong");
	slow_rate_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		$fell(SSI_CLK_O) && !fast_ff |-> ##99 !SSI_CLK_O ##1 SSI_CLK_O)
		else $error("slow serial clock low half wrong");
	mono_gap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin_ff && fast_ff |-> SSI_CLK_O throughout (##47 1))
		else $error("recovery gap too short");
	frame_len_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		len_ff >= epi_pkg::LEN_MIN && len_ff <= epi_pkg::LEN_MAX)
		else $error("frame length out of range");
	gray_dec_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		sample && gray_ff |=> dec_ff[0] == ($past(prev_bit_ff) ^ $past(data_s)))
		else $error("Gray bit not converted");
	frame_out_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin_ff |=> SSI_VALID_O && SSI_POS_O == ($past(dec_ff) >> $past(strip))
		&& SSI_PAR_ERR_O == $past(par_bad))
		else $error("frame result not right-justified");
	ssi_gray_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		SSI_VALID_O && gray_ff && par_en_ff);
endmodule

/* verilog/epi_pkg.sv */
// epi_pkg: constants for the encoder position input block
// assumes a 20 MHz system clock; the link sampling clock is free-running
// Functional notes
// - quadrature tracks a quarter period apart plus reference mark are decoded
// - quadrature tracks up to 420 kHz are counted without loss
// - track edges down to 200 ns apart are resolved
// - limit frequency setting spans 300..420 kHz, resets to 300 kHz
// - amplitude monitoring stays active at all speeds, faults are flagged
// - alarm flag is the LSB, parity next; parity is LSB without alarm
// - frame is all Gray or all binary; configured coding is decoded
// - frame length 13 to 25 bits including alarm and parity
// - position value is right-justified within the frame
// - serial clock runs at 100 kHz or 500 kHz
// - recovery gap between frames at least 12 us or 2.4 us
package epi_pkg;
	localparam int SYS_MHZ = 20;
	localparam int POS_W = 32;
	localparam int FRAME_W = 25;
	localparam int SSI_SLOW_KHZ = 100;
	localparam int SSI_FAST_KHZ = 500;
	localparam int SSI_HALF_SLOW = SYS_MHZ * 1000 / (2 * SSI_SLOW_KHZ);
	localparam int SSI_HALF_FAST = SYS_MHZ * 1000 / (2 * SSI_FAST_KHZ);
	localparam int TM_SLOW_NS = 12000;
	localparam int TM_FAST_NS = 2400;
	localparam int TM_SLOW_CYC = (TM_SLOW_NS * SYS_MHZ + 999) / 1000;
	localparam int TM_FAST_CYC = (TM_FAST_NS * SYS_MHZ + 999) / 1000;
	localparam int GATE_US = 1000;
	localparam int GATE_CYC = GATE_US * SYS_MHZ;
	localparam logic [4:0] LEN_MIN = 5'h0d;
	localparam logic [4:0] LEN_MAX = 5'h19;
	localparam logic [8:0] LIM_MIN_KHZ = 9'h12c;
	localparam logic [8:0] LIM_MAX_KHZ = 9'h1a4;
	localparam logic [8:0] LIM_RST_KHZ = LIM_MIN_KHZ;
	typedef enum logic [1:0] {
		SSI_IDLE,
		SSI_LOW,
		SSI_HIGH,
		SSI_MONO
	} epi_ssi_state_type;
endpackage

/* verilog/epi_sync.sv */
// epi_sync: two-flop synchroniser for a bundle of levels
// assumes each bit is a level or a slow one-step code; resets to zero
`timescale 1ns/1ps
module epi_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_ff <= '0;
			q_o <= '0;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule

/* dv/epi_ssi_enc.sv */
// epi_ssi_enc: behavioural absolute encoder on the far side of the serial link
// assumes the device clock idles high and word_i and len_i are steady during a frame
`timescale 1ns/1ps
module epi_ssi_enc (
	input wire logic sclk_i,
	input wire logic fast_i,
	input wire logic [4:0] len_i,
	input wire logic [24:0] word_i,
	output logic data_o
);
	int idx = 0;
	// msb first, a new bit on each falling clock edge; no incremental tracks here
	initial begin
		data_o = 1'b1;
		forever begin
			@(sclk_i);
			if (sclk_i === 1'b0) begin
				data_o = word_i[len_i - 5'h01 - idx[4:0]];
				idx = idx + 1;
			end else if (idx == int'(len_i)) begin
				// hold expires past the device sample point, so the line drops the last bit
				#(fast_i ? 1200 : 5200);
				data_o = ~data_o;
				idx = 0;
			end
		end
	end
endmodule

/* dv/encoder_position_input_test.sv */
// encoder_position_input_test: self-checking bench for epi_top
// assumes epi_pkg, epi_top and epi_ssi_enc are compiled before it
`timescale 1ns/1ps
module encoder_position_input_test;
	logic SYS_CLK_I = 1'b0, QDEC_CLK_I = 1'b0, RESETN_I = 1'b0;
	logic TRACK_A_I = 1'b0, TRACK_B_I = 1'b0, REF_MARK_I = 1'b0, AMP_OK_I = 1'b1;
	logic [8:0] LIMIT_KHZ_I = 9'h12c;
	logic LIMIT_LOAD_I = 1'b0, FAULT_CLR_I = 1'b0, SSI_EN_I = 1'b0, SSI_FAST_I = 1'b0;
	logic [4:0] SSI_LEN_I = 5'h19;
	logic SSI_GRAY_I = 1'b0, SSI_ALARM_EN_I = 1'b0, SSI_PAR_EN_I = 1'b0, SSI_PAR_ODD_I = 1'b0;
	logic SSI_DATA_I;
	logic [8:0] LIMIT_KHZ_O;
	logic [31:0] QPOS_O, REF_POS_O;
	logic QDIR_O, REF_SEEN_O, QUAD_ERR_O, FREQ_FAULT_O, AMP_FAULT_O, SSI_CLK_O;
	logic [24:0] SSI_POS_O;
	logic [24:0] word = 25'h0;
	logic SSI_VALID_O, SSI_ALARM_O, SSI_PAR_ERR_O, SSI_BUSY_O;
	logic [1:0] qph = 2'h0;
	logic [31:0] exp_pos = 32'h0;
	int error_cnt = 0;
	int comparisons = 0;

	epi_top #(.GATE_CYCLES(epi_pkg::GATE_CYC)) u_epi_top (
		.SYS_CLK_I, .RESETN_I, .QDEC_CLK_I, .TRACK_A_I, .TRACK_B_I, .REF_MARK_I,
		.AMP_OK_I, .LIMIT_KHZ_I, .LIMIT_LOAD_I, .FAULT_CLR_I, .SSI_EN_I, .SSI_FAST_I,
		.SSI_LEN_I, .SSI_GRAY_I, .SSI_ALARM_EN_I, .SSI_PAR_EN_I, .SSI_PAR_ODD_I,
		.SSI_DATA_I, .LIMIT_KHZ_O, .QPOS_O, .QDIR_O, .REF_POS_O, .REF_SEEN_O,
		.QUAD_ERR_O, .FREQ_FAULT_O, .AMP_FAULT_O, .SSI_CLK_O, .SSI_POS_O,
		.SSI_VALID_O, .SSI_ALARM_O, .SSI_PAR_ERR_O, .SSI_BUSY_O
	);
	epi_ssi_enc u_epi_ssi_enc (.sclk_i(SSI_CLK_O), .fast_i(SSI_FAST_I), .len_i(SSI_LEN_I),
		.word_i(word), .data_o(SSI_DATA_I));

	initial forever #25 SYS_CLK_I = ~SYS_CLK_I;
	// link clock period and phase unrelated to the system clock
	initial begin
		#3;
		forever #6 QDEC_CLK_I = ~QDEC_CLK_I;
	end

	task automatic close_out;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step(inout int n);
		@(posedge SYS_CLK_I);
		#1;
		n++;
		if (n > 30000) begin
			check("wait bound", 32'h0, 32'h1);
			close_out();
		end
	endtask

	task automatic load_limit(input logic [8:0] v);
		@(posedge SYS_CLK_I);
		LIMIT_KHZ_I <= v;
		LIMIT_LOAD_I <= 1'b1;
		@(posedge SYS_CLK_I);
		LIMIT_LOAD_I <= 1'b0;
		#1;
	endtask

	task automatic clear_faults;
		@(posedge SYS_CLK_I);
		FAULT_CLR_I <= 1'b1;
		@(posedge SYS_CLK_I);
		FAULT_CLR_I <= 1'b0;
		repeat (2) @(posedge SYS_CLK_I);
		#1;
	endtask

	// one quadrature edge every gap cycles; phase 0,1,2,3 gives AB 00,10,11,01
	task automatic quad(input logic up, input int n, input int gap);
		repeat (n) begin
			@(posedge SYS_CLK_I);
			qph = up ? qph + 2'h1 : qph - 2'h1;
			TRACK_A_I <= ^qph;
			TRACK_B_I <= qph[1];
			exp_pos = up ? exp_pos + 32'h1 : exp_pos - 32'h1;
			repeat (gap - 1) @(posedge SYS_CLK_I);
		end
		repeat (12) @(posedge SYS_CLK_I);
		#1;
	endtask

	task automatic t_reset;
		check("limit reset", LIMIT_KHZ_O, 32'h12c);
		check("ssi clk idle", SSI_CLK_O, 1'h1);
		check("pos reset", QPOS_O, 32'h0);
		check("faults idle", {QUAD_ERR_O, FREQ_FAULT_O, AMP_FAULT_O, SSI_BUSY_O}, 4'h0);
		$display("test reset done");
	endtask

	task automatic t_limit;
		logic [8:0] v [5] = '{9'h15e, 9'h1f4, 9'h064, 9'h1a4, 9'h12b};
		logic [8:0] e [5] = '{9'h15e, 9'h1a4, 9'h12c, 9'h1a4, 9'h12c};
		foreach (v[i]) begin
			load_limit(v[i]);
			check("limit", LIMIT_KHZ_O, e[i]);
		end
		$display("test limit done");
	endtask

	task automatic t_quad;
		quad(1'b1, 8, 4);
		check("pos up", QPOS_O, exp_pos);
		check("dir up", QDIR_O, 1'h1);
		@(posedge SYS_CLK_I);
		REF_MARK_I <= 1'b1;
		repeat (8) @(posedge SYS_CLK_I);
		REF_MARK_I <= 1'b0;
		#1;
		check("ref pos", REF_POS_O, exp_pos);
		check("ref seen", REF_SEEN_O, 1'h1);
		quad(1'b0, 11, 4);
		check("pos down", QPOS_O, exp_pos);
		check("dir down", QDIR_O, 1'h0);
		check("quad err", QUAD_ERR_O, 1'h0);
		// both tracks flip in one edge: refused, no count
		@(posedge SYS_CLK_I);
		qph = qph + 2'h2;
		TRACK_A_I <= ^qph;
		TRACK_B_I <= qph[1];
		repeat (12) @(posedge SYS_CLK_I);
		#1;
		check("double step err", QUAD_ERR_O, 1'h1);
		check("double step pos", QPOS_O, exp_pos);
		clear_faults();
		check("quad err clear", QUAD_ERR_O, 1'h0);
		$display("test quad done");
	endtask

	// about 417 kHz for over a window: legal at 420; then 1250 kHz, overspeed at the default 300
	task automatic t_freq;
		load_limit(9'h1a4);
		quad(1'b1, 2640, 12);
		check("pos fast", QPOS_O, exp_pos);
		check("no overspeed", FREQ_FAULT_O, 1'h0);
		@(posedge SYS_CLK_I);
		AMP_OK_I <= 1'b0;
		repeat (5) @(posedge SYS_CLK_I);
		#1;
		check("amp fault", AMP_FAULT_O, 1'h1);
		@(posedge SYS_CLK_I);
		AMP_OK_I <= 1'b1;
		repeat (4) @(posedge SYS_CLK_I);
		clear_faults();
		check("amp clear", AMP_FAULT_O, 1'h0);
		load_limit(9'h12c);
		quad(1'b0, 2800, 4);
		check("pos fast down", QPOS_O, exp_pos);
		check("overspeed", FREQ_FAULT_O, 1'h1);
		// the window count stands until the window ends and would set the flag again
		repeat (epi_pkg::GATE_CYC) @(posedge SYS_CLK_I);
		clear_faults();
		check("overspeed clear", FREQ_FAULT_O, 1'h0);
		$display("test freq done");
	endtask

	// two frames back to back, the second one ends the run of frames
	task automatic frame(input logic fast, gray, al_en, pr_en, odd, input logic [4:0] len,
			input logic [24:0] pos, input logic alarm, bad);
		logic [24:0] bin;
		logic [1:0] sh;
		logic par;
		int n, half, tm;
		sh = {1'b0, al_en} + {1'b0, pr_en};
		pos = pos & ((25'h1 << (len - {3'h0, sh})) - 25'h1);
		par = ^pos ^ odd ^ bad;
		bin = (pos << sh) | ({24'h0, par & pr_en} << al_en) | {24'h0, alarm & al_en};
		word = gray ? bin ^ (bin >> 1) : bin;
		half = fast ? epi_pkg::SSI_HALF_FAST : epi_pkg::SSI_HALF_SLOW;
		tm = fast ? epi_pkg::TM_FAST_CYC : epi_pkg::TM_SLOW_CYC;
		@(posedge SYS_CLK_I);
		SSI_FAST_I <= fast;
		SSI_GRAY_I <= gray;
		SSI_ALARM_EN_I <= al_en;
		SSI_PAR_EN_I <= pr_en;
		SSI_PAR_ODD_I <= odd;
		SSI_LEN_I <= len;
		SSI_EN_I <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			n = 0;
			while (SSI_CLK_O !== 1'b0) step(n);
			if (i == 1) check("ssi gap", n >= tm - 3, 1'h1);
			n = 0;
			while (SSI_CLK_O === 1'b0) step(n);
			check("ssi half", n, half);
			check("ssi busy", SSI_BUSY_O, 1'h1);
			if (i == 1) @(posedge SYS_CLK_I) SSI_EN_I <= 1'b0;
			n = 0;
			while (SSI_VALID_O !== 1'b1) step(n);
			check("ssi pos", SSI_POS_O, pos);
			check("ssi gap idle", SSI_BUSY_O, 1'h0);
			check("ssi alarm", SSI_ALARM_O, alarm & al_en);
			check("ssi parity", SSI_PAR_ERR_O, bad & pr_en);
		end
	endtask

	task automatic t_ssi;
		frame(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h19, 25'h0a5c3e1, 1'b0, 1'b0);
		frame(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 5'h0d, 25'h01b2d, 1'b1, 1'b0);
		frame(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 5'h0d, 25'h00f0f, 1'b0, 1'b1);
		frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h19, 25'h1abcdef, 1'b0, 1'b0);
		$display("test ssi done");
	endtask

	initial begin
		repeat (20) @(posedge SYS_CLK_I);
		RESETN_I <= 1'b1;
		repeat (2) @(posedge SYS_CLK_I);
		#1;
		t_reset();
		t_limit();
		t_quad();
		t_freq();
		t_ssi();
		close_out();
	end
endmodule
